// file: dv/host_sink.sv
// host side model: takes result words, alternating prompt and slow ready
`timescale 1ns/1ps
module host_sink (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // result stream
  input wire logic out_valid,
  input wire logic [1:0] out_tag,
  input wire logic [31:0] out_data,
  output logic out_ready,
  // bench control
  input wire logic hold
);
  logic cyc_q;
  logic cyc_d;
  logic [33:0] rx_q [$];

  // ==========================================
  // ready pattern: every other cycle, none while held
  always_comb begin
    cyc_d = ~cyc_q;
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      cyc_q <= 1'b0;
    end else begin
      cyc_q <= cyc_d;
    end
  end

  assign out_ready = cyc_q & ~hold;

  // ==========================================
  // collect accepted words for the bench
  always @(posedge sys_clk) begin
    if (!reset && out_valid && out_ready) begin
      rx_q.push_back({out_tag, out_data});
    end
  end
endmodule : host_sink

// file: dv/tb_top.sv
// self-checking bench of the disparity and timestamp tagger
`timescale 1ns/1ps
module tb_top;
  import tagger_pkg::*;
  typedef struct packed {
    logic bad;
    logic [11:0] col;
    logic [11:0] disp;
    logic [11:0] exp;
  } pix_row_t;

  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic [5:0] reg_addr = 6'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_we = 1'b0;
  logic reg_re = 1'b0;
  logic [31:0] reg_rdata;
  logic pix_valid = 1'b0;
  logic pix_ready;
  logic pix_sof = 1'b0;
  logic pix_eof = 1'b0;
  logic pix_bad = 1'b0;
  logic [11:0] pix_col = 12'h0;
  logic [11:0] pix_disp = 12'h0;
  logic trig_pulse = 1'b0;
  logic sync_pin = 1'b0;
  logic [63:0] net_ts = 64'h0;
  logic [31:0] net_seq = 32'h0;
  logic out_valid;
  logic out_ready;
  logic [1:0] out_tag;
  logic [31:0] out_data;
  logic hold = 1'b0;
  logic [31:0] rd_v;
  logic [63:0] ts;
  logic [31:0] t0;
  int err_count = 0;
  int samples_checked = 0;
  // dmin 1, dmax 8, border on
  pix_row_t rows [7] = '{
    '{1'b0, 12'h014, 12'h020, 12'h020},
    '{1'b1, 12'h014, 12'h020, 12'hFFF},
    '{1'b0, 12'h014, 12'h00F, 12'hFFF},
    '{1'b0, 12'h014, 12'h081, 12'hFFF},
    '{1'b0, 12'h014, 12'h080, 12'h080},
    '{1'b0, 12'h007, 12'h030, 12'hFFF},
    '{1'b0, 12'h008, 12'h030, 12'h030}};

  always #5 sys_clk = ~sys_clk;

  disparity_timestamp_tagger #(.FIFO_DEPTH(16)) u_dut (
    .sys_clk(sys_clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata), .pix_valid(pix_valid),
    .pix_ready(pix_ready), .pix_sof(pix_sof), .pix_eof(pix_eof), .pix_bad(pix_bad),
    .pix_col(pix_col), .pix_disp(pix_disp), .trig_pulse(trig_pulse), .sync_pin(sync_pin),
    .net_ts(net_ts), .net_seq(net_seq), .out_valid(out_valid), .out_ready(out_ready),
    .out_tag(out_tag), .out_data(out_data));

  host_sink u_host (
    .sys_clk(sys_clk), .reset(reset), .out_valid(out_valid), .out_tag(out_tag),
    .out_data(out_data), .out_ready(out_ready), .hold(hold));

  // ==========================================
  // shared tasks
  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    reg_we <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_we <= 1'b0;
    @(posedge sys_clk);
  endtask : wr

  task automatic rd(input logic [5:0] a, output logic [31:0] d);
    reg_re <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_re <= 1'b0;
    @(posedge sys_clk);
    d = reg_rdata;
  endtask : rd

  task automatic rd_check(input logic [5:0] a, input logic [31:0] exp);
    rd(a, rd_v);
    check(rd_v, exp);
  endtask : rd_check

  task automatic send_frame();
    int n;
    for (int i = 0; i < 7; i++) begin
      pix_valid <= 1'b1;
      pix_sof <= (i == 0);
      pix_eof <= (i == 6);
      pix_bad <= rows[i].bad;
      pix_col <= rows[i].col;
      pix_disp <= rows[i].disp;
      n = 0;
      do begin
        @(posedge sys_clk);
        n++;
      end while (pix_ready !== 1'b1 && n < 500);
    end
    pix_valid <= 1'b0;
  endtask : send_frame

  task automatic check_frame(input logic [31:0] exp_seq, output logic [63:0] t);
    logic [33:0] w;
    int n;
    n = 0;
    while (u_host.rx_q.size() < 26 && n < 2000) begin
      @(posedge sys_clk);
      n++;
    end
    check(n < 2000, 1'b1);
    for (int i = 0; i < 16; i++) begin
      check(u_host.rx_q.pop_front(), {2'h1, 32'h0100_0000 + i});
    end
    w = u_host.rx_q.pop_front();
    check(w[33:32], 2'h1);
    t[31:0] = w[31:0];
    w = u_host.rx_q.pop_front();
    check(w[33:32], 2'h1);
    t[63:32] = w[31:0];
    check(u_host.rx_q.pop_front(), {2'h1, exp_seq});
    for (int i = 0; i < 7; i++) begin
      w = {(i == 6) ? 2'h2 : 2'h0, 20'h0, rows[i].exp};
      check(u_host.rx_q.pop_front(), w);
    end
  endtask : check_frame

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : test_done

  initial begin
    repeat (20000) @(posedge sys_clk);
    err_count++;
    test_done();
  end

  // ==========================================
  // main sequence
  initial begin
    repeat (5) @(posedge sys_clk);
    reset <= 1'b0;
    @(posedge sys_clk);
    rd_check(6'h02, 32'h1DBE_A000);
    rd_check(6'h03, 32'h0005_44FD);
    rd_check(6'h00, 32'h0000_0010);
    rd_check(6'h01, 32'h006F_0000);
    rd_check(6'h04, 32'h0);
    rd_check(6'h3F, 32'h0);
    // sync edge without pulse mode leaves the clock
    sync_pin <= 1'b1;
    repeat (10) @(posedge sys_clk);
    rd_check(6'h03, 32'h0005_44FD);
    sync_pin <= 1'b0;
    for (int i = 0; i < 16; i++) begin
      wr(6'h10 + 6'(i), 32'h0100_0000 + i);
    end
    wr(6'h01, 32'h0008_0001);
    wr(6'h00, 32'h0000_0011);
    wr(6'h02, 32'h0000_1000);
    wr(6'h03, 32'h0000_0002);
    trig_pulse <= 1'b1;
    @(posedge sys_clk);
    trig_pulse <= 1'b0;
    rd_check(6'h03, 32'h0000_0002);
    send_frame();
    check_frame(32'h0, ts);
    check((ts - 64'h0000_0002_0000_1000) <= 64'h1, 1'b1);
    rd_check(6'h04, 32'h1);
    // stalled host, stamp taken at frame arrival
    wr(6'h00, 32'h0000_0015);
    rd(6'h02, t0);
    hold <= 1'b1;
    fork
      send_frame();
      begin
        repeat (60) @(posedge sys_clk);
        rd(6'h05, rd_v);
        check(rd_v[4:0], 5'h10);
        hold <= 1'b0;
      end
    join
    check_frame(32'h1, ts);
    check(ts[63:32], 32'h2);
    check((ts[31:0] - t0) <= 32'h1, 1'b1);
    rd(6'h05, rd_v);
    check(rd_v[4:0], 5'h00);
    // network frames pass stamp and sequence
    net_ts <= 64'h0123_4567_89AB_CDEF;
    net_seq <= 32'h0000_0055;
    wr(6'h00, 32'h0000_0018);
    send_frame();
    check_frame(32'h0000_0055, ts);
    check(ts, 64'h0123_4567_89AB_CDEF);
    rd_check(6'h04, 32'h2);
    // pulse sync while a triggered stamp is pending
    wr(6'h00, 32'h0000_0012);
    trig_pulse <= 1'b1;
    @(posedge sys_clk);
    trig_pulse <= 1'b0;
    repeat (300) @(posedge sys_clk);
    sync_pin <= 1'b1;
    repeat (10) @(posedge sys_clk);
    rd_check(6'h03, 32'h0);
    send_frame();
    check_frame(32'h2, ts);
    check($signed(ts) <= -64'sd2 && $signed(ts) >= -64'sd5, 1'b1);
    sync_pin <= 1'b0;
    test_done();
  end
endmodule : tb_top

// file: hw/disparity_timestamp_tagger.sv
// disparity coder, time base and frame tagger of the stereo matcher output
`timescale 1ns/1ps
`include "tagger_defines.svh"
module disparity_timestamp_tagger
  import tagger_pkg::*;
#(
  parameter int FIFO_DEPTH = 16
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // register port
  input wire logic [5:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_we,
  input wire logic reg_re,
  output logic [31:0] reg_rdata,
  // matcher pixel stream
  input wire logic pix_valid,
  output logic pix_ready,
  input wire logic pix_sof,
  input wire logic pix_eof,
  input wire logic pix_bad,
  input wire logic [11:0] pix_col,
  input wire logic [`DISP_W-1:0] pix_disp,
  // time events
  input wire logic trig_pulse,
  input wire logic sync_pin,
  // network frame metadata
  input wire logic [63:0] net_ts,
  input wire logic [31:0] net_seq,
  // result stream
  output logic out_valid,
  input wire logic out_ready,
  output logic [1:0] out_tag,
  output logic [31:0] out_data
);
  localparam int FW = 34;
  localparam logic [6:0] US_LAST = 7'(`US_CYCLES - 1);

  if (FIFO_DEPTH > 16) begin : g_depth_chk
    $error("status field holds a fill level of at most 16");
  end

  stream_if #(.W(FW)) fin ();
  stream_if #(.W(FW)) fout ();
  logic [$clog2(FIFO_DEPTH):0] fifo_level;

  tag_fifo #(.W(FW), .DEPTH(FIFO_DEPTH)) u_fifo (
    .sys_clk(sys_clk),
    .reset(reset),
    .wr(fin.snk),
    .rd(fout.src),
    .level(fifo_level)
  );

  assign out_valid = fout.valid;
  assign fout.ready = out_ready;
  assign out_tag = fout.data[33:32];
  assign out_data = fout.data[31:0];

  // ==========================================
  // disparity coding
  function automatic logic [`DISP_W-1:0] disp_code(
    input logic [`DISP_W-1:0] disp,
    input logic bad,
    input logic [11:0] col,
    input logic [`RANGE_W-1:0] dmin,
    input logic [`RANGE_W-1:0] dmax,
    input logic border
  );
    logic [`RANGE_W+`DISP_FRAC-1:0] lo, hi, dv;
    lo = {dmin, {`DISP_FRAC{1'b0}}};
    hi = {dmax, {`DISP_FRAC{1'b0}}};
    dv = (`RANGE_W + `DISP_FRAC)'(disp);
    if (bad || dv < lo || dv > hi || (border && col < 12'(dmax))) begin
      return `DISP_INVALID;
    end
    return disp;
  endfunction : disp_code

  // ==========================================
  // registers
  logic [31:0] ctrl_q, ctrl_d, range_q, range_d, lo_q, lo_d, rdata_q, rdata_d;
  logic [31:0] qm_q [16];
  logic [31:0] qm_d [16];
  logic [63:0] time_q, time_d;
  logic signed [63:0] cap_q, cap_d;
  logic [31:0] seq_q, seq_d, fseq_q, fseq_d;
  logic pend_q, pend_d;
  frame_state_t st_q, st_d;
  time_mode_t mode;
  logic src_frame, net_in, border_en;
  logic [`RANGE_W-1:0] dmin, dmax;

  assign mode = time_mode_t'(ctrl_q[`CTRL_MODE_LSB +: 2]);
  assign src_frame = ctrl_q[`CTRL_SRC_BIT];
  assign net_in = ctrl_q[`CTRL_NET_BIT];
  assign border_en = ctrl_q[`CTRL_BORDER_BIT];
  assign dmin = range_q[`RANGE_MIN_LSB +: `RANGE_W];
  assign dmax = range_q[`RANGE_MAX_LSB +: `RANGE_W];
  assign reg_rdata = rdata_q;

  always_comb begin
    ctrl_d = ctrl_q;
    range_d = range_q;
    lo_d = lo_q;
    qm_d = qm_q;
    rdata_d = '0;
    if (reg_we) begin
      if (reg_addr == `REG_CTRL) ctrl_d = reg_wdata;
      if (reg_addr == `REG_RANGE) range_d = reg_wdata;
      if (reg_addr == `REG_TIME_LO) lo_d = reg_wdata;
      if (reg_addr[5:4] == `REG_QMAT_HI) qm_d[reg_addr[3:0]] = reg_wdata;
    end
    if (reg_re) begin
      if (reg_addr[5:4] == `REG_QMAT_HI) begin
        rdata_d = qm_q[reg_addr[3:0]];
      end else begin
        unique case (reg_addr)
          `REG_CTRL: rdata_d = ctrl_q;
          `REG_RANGE: rdata_d = range_q;
          `REG_TIME_LO: rdata_d = time_q[31:0];
          `REG_TIME_HI: rdata_d = time_q[63:32];
          `REG_SEQ: rdata_d = seq_q;
          `REG_STATUS: rdata_d = {21'h0, pend_q, st_q, 3'h0, 5'(fifo_level)};
          default: rdata_d = '0;
        endcase
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      ctrl_q <= `CTRL_RST;
      range_q <= `RANGE_RST;
      lo_q <= '0;
      rdata_q <= '0;
      qm_q <= '{default: 32'h0};
    end else begin
      ctrl_q <= ctrl_d;
      range_q <= range_d;
      lo_q <= lo_d;
      rdata_q <= rdata_d;
      qm_q <= qm_d;
    end
  end

  // ==========================================
  // time base
  logic [2:0] sync_q, sync_d;
  logic lvl_q, lvl_d, pps_edge, pps_zero, srv_load, us_tick;
  logic [6:0] div_q, div_d;

  assign pps_edge = (sync_q[1] == sync_q[2]) && sync_q[2] && !lvl_q;
  assign pps_zero = pps_edge && mode == TM_PPS;
  assign srv_load = reg_we && reg_addr == `REG_TIME_HI && mode == TM_SERVER;
  assign us_tick = div_q == US_LAST;

  always_comb begin
    sync_d = {sync_q[1:0], sync_pin};
    lvl_d = (sync_q[1] == sync_q[2]) ? sync_q[2] : lvl_q;
    div_d = us_tick ? '0 : div_q + 1'b1;
    time_d = us_tick ? time_q + 64'h1 : time_q;
    if (pps_zero) begin
      time_d = '0;
      div_d = '0;
    end else if (srv_load) begin
      time_d = {reg_wdata, lo_q};
      div_d = '0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      sync_q <= '0;
      lvl_q <= 1'b0;
      div_q <= '0;
      time_q <= `TIME_RST;
    end else begin
      sync_q <= sync_d;
      lvl_q <= lvl_d;
      div_q <= div_d;
      time_q <= time_d;
    end
  end

  // ==========================================
  // frame tagging
  logic [4:0] hidx_q, hidx_d;
  logic sof_in, cap_evt, hdr_take, pix_take;

  function automatic logic [31:0] hdr_word(
    input logic [4:0] idx,
    input logic [31:0] qm [16],
    input logic [63:0] ts,
    input logic [31:0] sq
  );
    if (idx < 5'(`HDR_TS_LO)) return qm[idx[3:0]];
    if (idx == 5'(`HDR_TS_LO)) return ts[31:0];
    if (idx == 5'(`HDR_TS_LO + 1)) return ts[63:32];
    return sq;
  endfunction : hdr_word

  assign sof_in = st_q == ST_IDLE && pix_valid && pix_sof;
  assign cap_evt = !net_in && (src_frame ? sof_in : trig_pulse);
  assign hdr_take = st_q == ST_HDR && fin.ready;
  assign pix_take = st_q == ST_PIX && pix_valid && fin.ready;

  always_comb begin
    fin.valid = 1'b0;
    fin.data = '0;
    pix_ready = st_q == ST_IDLE && !pix_sof;
    unique case (st_q)
      ST_HDR: begin
        fin.valid = 1'b1;
        fin.data = {TAG_HDR, hdr_word(hidx_q, qm_q, cap_q, fseq_q)};
      end
      ST_PIX: begin
        fin.valid = pix_valid;
        pix_ready = fin.ready;
        fin.data = {pix_eof ? TAG_LAST : TAG_PIX, 20'h0,
          disp_code(pix_disp, pix_bad, pix_col, dmin, dmax, border_en)};
      end
      ST_IDLE: begin
      end
    endcase
  end

  always_comb begin
    st_d = st_q;
    hidx_d = hidx_q;
    cap_d = cap_q;
    pend_d = pend_q;
    seq_d = seq_q;
    fseq_d = fseq_q;
    if (pps_zero && pend_q) cap_d = cap_q - $signed(time_q);
    if (cap_evt) begin
      cap_d = pps_zero ? '0 : $signed(time_q);
      pend_d = 1'b1;
    end
    unique case (st_q)
      ST_IDLE: if (sof_in) begin
        st_d = ST_HDR;
        hidx_d = '0;
        fseq_d = net_in ? net_seq : seq_q;
        if (net_in) begin
          cap_d = $signed(net_ts);
          pend_d = 1'b0;
        end
      end
      ST_HDR: if (hdr_take) begin
        hidx_d = hidx_q + 1'b1;
        if (hidx_q == 5'(`HDR_TS_LO)) pend_d = cap_evt;
        if (hidx_q == 5'(`HDR_WORDS - 1)) st_d = ST_PIX;
      end
      ST_PIX: if (pix_take && pix_eof) begin
        st_d = ST_IDLE;
        if (!net_in) seq_d = seq_q + 32'h1;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      st_q <= ST_IDLE;
      hidx_q <= '0;
      cap_q <= '0;
      pend_q <= 1'b0;
      seq_q <= '0;
      fseq_q <= '0;
    end else begin
      st_q <= st_d;
      hidx_q <= hidx_d;
      cap_q <= cap_d;
      pend_q <= pend_d;
      seq_q <= seq_d;
      fseq_q <= fseq_d;
    end
  end

  // ==========================================
  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  sequence s_frame_end;
    pix_take && pix_eof && !net_in;
  endsequence
  sequence s_sync_zero;
    pps_edge && mode == TM_PPS && !srv_load;
  endsequence

  a_invalid_code: assert property (pix_take && pix_bad |-> fin.data[11:0] == 12'hFFF)
    else $error("rejected disparity not coded as all ones");
  a_border_mark: assert property (pix_take && border_en && pix_col < 12'(dmax)
    |-> fin.data[11:0] == 12'hFFF) else $error("border pixel not invalid");
  a_range_reject: assert property (pix_take && {2'b0, pix_disp} > {dmax, 4'h0}
    |-> fin.data[11:0] == 12'hFFF) else $error("out of range disparity kept");
  a_disp_pass: assert property (pix_take && !pix_bad
    && (!border_en || pix_col >= 12'(dmax)) && {2'b0, pix_disp} >= {dmin, 4'h0}
    && {2'b0, pix_disp} <= {dmax, 4'h0} |-> fin.data[31:0] == {20'h0, pix_disp})
    else $error("valid disparity altered");
  a_hdr_matrix: assert property (st_q == ST_HDR && hidx_q < 5'd16
    |-> fin.data[31:0] == qm_q[hidx_q[3:0]]) else $error("matrix word wrong");
  a_seq_step: assert property (s_frame_end |=> seq_q == $past(seq_q) + 32'h1)
    else $error("sequence not incremented");
  a_net_seq: assert property (sof_in && net_in |=> fseq_q == $past(net_seq)
    && cap_q == $past(net_ts)) else $error("network metadata not copied");
  a_pps_zero: assert property (s_sync_zero
    |=> time_q == 64'h0 ##1 time_q == 64'h0) else $error("sync edge did not zero clock");
  a_pps_gated: assert property (pps_edge && mode != TM_PPS && !srv_load
    |=> time_q >= $past(time_q)) else $error("clock zeroed without pulse sync");
  a_tick_gap: assert property (us_tick |=> !us_tick [*8])
    else $error("microsecond tick too frequent");
  a_neg_stamp: assert property (s_sync_zero and (pend_q && !cap_evt && !net_in)
    |=> cap_q == $past(cap_q) - $signed($past(time_q))) else $error("negative stamp wrong");
  a_srv_load: assert property (srv_load && !pps_zero
    |=> time_q == {$past(reg_wdata), $past(lo_q)}) else $error("server time not loaded");
  a_reset_epoch: assert property ($fell(reset) |-> time_q == `TIME_RST)
    else $error("clock not at start value after reset");
endmodule : disparity_timestamp_tagger

// file: hw/stream_if.sv
// valid/ready word stream between tagger modules
`timescale 1ns/1ps
interface stream_if #(parameter int W = 34) ();
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : stream_if

// file: hw/tag_fifo.sv
// flip-flop FIFO with valid/ready on both sides
`timescale 1ns/1ps
module tag_fifo #(
  parameter int W = 34,
  parameter int DEPTH = 16
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // streams
  stream_if.snk wr,
  stream_if.src rd,
  // fill level
  output logic [$clog2(DEPTH):0] level
);
  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << AW) != DEPTH || W < 1) begin : g_chk
    $error("tag_fifo: DEPTH must be a power of two of at least 2");
  end

  logic [W-1:0] mem_q [DEPTH];
  logic [W-1:0] mem_d [DEPTH];
  logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
  logic [AW:0] cnt_q, cnt_d;
  logic push, pop;

  assign wr.ready = cnt_q != (AW + 1)'(DEPTH);
  assign rd.valid = cnt_q != '0;
  assign rd.data = mem_q[rp_q];
  assign level = cnt_q;
  assign push = wr.valid && wr.ready;
  assign pop = rd.valid && rd.ready;

  always_comb begin
    mem_d = mem_q;
    wp_d = wp_q;
    rp_d = rp_q;
    cnt_d = cnt_q;
    if (push) begin
      mem_d[wp_q] = wr.data;
      wp_d = wp_q + 1'b1;
    end
    if (pop) begin
      rp_d = rp_q + 1'b1;
    end
    if (push && !pop) begin
      cnt_d = cnt_q + 1'b1;
    end else if (pop && !push) begin
      cnt_d = cnt_q - 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end else begin
      wp_q <= wp_d;
      rp_q <= rp_d;
      cnt_q <= cnt_d;
    end
    mem_q <= mem_d;
  end

  a_fifo_bound: assert property (@(posedge sys_clk) disable iff (reset)
    cnt_q <= (AW + 1)'(DEPTH)) else $error("fifo count past depth");
endmodule : tag_fifo

// file: hw/tagger_defines.svh
// register offsets, field positions, reset values and timing counts of the tagger
`ifndef TAGGER_DEFINES_SVH
`define TAGGER_DEFINES_SVH

// ==========================================
// register word indices
`define REG_CTRL 6'h00
`define REG_RANGE 6'h01
`define REG_TIME_LO 6'h02
`define REG_TIME_HI 6'h03
`define REG_SEQ 6'h04
`define REG_STATUS 6'h05
`define REG_QMAT_HI 2'h1

// ==========================================
// field positions
`define CTRL_MODE_LSB 0
`define CTRL_SRC_BIT 2
`define CTRL_NET_BIT 3
`define CTRL_BORDER_BIT 4
`define RANGE_MIN_LSB 0
`define RANGE_MAX_LSB 16
`define RANGE_W 10

// ==========================================
// reset values
`define CTRL_RST 32'h0000_0010
`define RANGE_RST 32'h006F_0000
`define TIME_RST 64'h0005_44FD_1DBE_A000

// ==========================================
// disparity coding
`define DISP_W 12
`define DISP_FRAC 4
`define DISP_INVALID 12'hFFF

// ==========================================
// timing
`define US_NS 1000
`define CLK_NS 10
`define US_CYCLES (`US_NS / `CLK_NS)
`define HDR_WORDS 19
`define HDR_TS_LO 16

`endif

// file: hw/tagger_pkg.sv
// types shared by the tagger modules
package tagger_pkg;
  typedef enum logic [1:0] {TM_FREE, TM_SERVER, TM_PPS} time_mode_t;
  typedef enum logic [1:0] {TAG_PIX, TAG_HDR, TAG_LAST} word_tag_t;
  typedef enum logic [1:0] {ST_IDLE, ST_HDR, ST_PIX} frame_state_t;
endpackage : tagger_pkg
